// *** core/cond_match.v ***
// Purpose: Per-bit match of one status word against its enable and state words.
// Assumes: Inputs synchronous to aclk.
// Notes: Pure combinational reduction.
`timescale 1ns/1ps
module cond_match #(
  parameter W = 16
) (
  input  wire [W-1:0] status_word,
  input  wire [W-1:0] enable_word,
  input  wire [W-1:0] state_word,
  output wire         hit
);
  wire [W-1:0] bit_hit;
  genvar i;
  generate
    for (i = 0; i < W; i = i + 1) begin : g_bit
      // A disabled bit never contributes.
      assign bit_hit[i] = enable_word[i] & ~(status_word[i] ^ state_word[i]);
    end
  endgenerate
  assign hit = |bit_hit;
endmodule

// *** core/kill_monitor_defines.vh ***
// Purpose: Constants for the motor shutdown supervisor.
// Assumes: Included by bare name from the monitor and loader design files.
// Notes: Register offsets are byte addresses on the AXI4-Lite slave.
`ifndef KILL_MONITOR_DEFINES_VH
`define KILL_MONITOR_DEFINES_VH
`define OFS_ENABLE_PRI     8'h00
`define OFS_STATE_PRI      8'h04
`define OFS_ENABLE_SEC     8'h08
`define OFS_STATE_SEC      8'h0C
`define OFS_ENABLE_XIO     8'h10
`define OFS_STATE_XIO      8'h14
`define OFS_RECOVERY       8'h18
`define OFS_PROC_TRIP      8'h1C
`define OFS_DRV_TRIP       8'h20
`define OFS_CONTROL        8'h24
`define OFS_STATUS         8'h28
`define OFS_CLEAR          8'h2C
`define OFS_CMD            8'h30
`define OVERTEMP_BIT       7
`define INPUT1_BIT         4
`define MOVE_ERR_BIT       8
`define LOW_VOLT_BIT       14
`define ENABLE_PRI_RESET   16'h0080
`define STATE_PRI_RESET    16'h0000
`define RECOVERY_RESET     16'h0000
`define PROC_TRIP_RESET    16'h0000
`define DRV_TRIP_RESET     16'h000A
`define RECOVERY_NONE      16'h0000
`define RECOVERY_ADDR0     16'hFFFF
`define OPC_COND_CONFIG    16'h00A7
`define OPC_COND_CONFIG_EXT 16'h00DC
`define OPC_RECOVERY       16'h00B5
`define OPC_PROC_TRIP      16'h0083
`define OPC_DRV_TRIP       16'h00D4
`define CTL_KEEP_BIT       0
`define CTL_MULTI_BIT      1
`define CTL_DRV_EN_BIT     2
`define ST_KILLED_BIT      0
`define ST_OVERVOLT_BIT    1
`define ST_LOWVOLT_BIT     2
`define RESP_OKAY          2'b00
`define RESP_SLVERR        2'b10
`endif

// *** core/motor_kill_condition_monitor.v ***
// Purpose: Shutdown supervisor: condition match, over-voltage, recovery and supply trip.
// Assumes: Status words and measured voltages are synchronous to aclk.
// Notes: Configuration arrives over AXI4-Lite or as serial command words.
//
// Our own choices: the register addresses and the AXI4-Lite register port.
`timescale 1ns/1ps
`include "kill_monitor_defines.vh"
module motor_kill_condition_monitor (
  input  wire        aclk,
  input  wire        aresetn,
  input  wire [7:0]  s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output wire        s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output wire        s_axi_wready,
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [7:0]  s_axi_araddr,
  input  wire        s_axi_arvalid,
  output wire        s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  input  wire        cmd_valid,
  input  wire [15:0] cmd_word,
  input  wire [15:0] primary_status_word,
  input  wire [15:0] secondary_status_word,
  input  wire [15:0] extended_io_word,
  input  wire        overvolt,
  input  wire [15:0] processor_volts,
  output reg         driver_enable,
  output reg         short_windings,
  output reg         abort_motion,
  output reg         recovery_start,
  output reg  [15:0] recovery_addr,
  output reg         low_voltage_status,
  output reg         power_low_start
);
  reg [15:0] en_pri_q;
  reg [15:0] st_pri_q;
  reg [15:0] en_sec_q;
  reg [15:0] st_sec_q;
  reg [15:0] en_xio_q;
  reg [15:0] st_xio_q;
  reg [15:0] recovery_q;
  reg [15:0] proc_trip_q;
  reg [15:0] drv_trip_q;
  reg        keep_q;
  reg        multi_q;
  reg        killed_q;
  reg        ov_seen_q;
  reg        aw_q;
  reg        w_q;
  reg [7:0]  awaddr_q;
  reg [31:0] wdata_q;
  reg [3:0]  wstrb_q;

  wire        ld_done;
  wire [15:0] ld_opcode;
  wire [95:0] ld_args;
  wire        hit_pri;
  wire        hit_sec;
  wire        hit_xio;

  word_loader u_loader (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .cmd_valid (cmd_valid),
    .cmd_word  (cmd_word),
    .done      (ld_done),
    .opcode    (ld_opcode),
    .args      (ld_args)
  );

  cond_match #(.W(16)) u_pri (
    .status_word (primary_status_word),
    .enable_word (en_pri_q),
    .state_word  (st_pri_q),
    .hit         (hit_pri)
  );
  cond_match #(.W(16)) u_sec (
    .status_word (secondary_status_word),
    .enable_word (en_sec_q),
    .state_word  (st_sec_q),
    .hit         (hit_sec)
  );
  cond_match #(.W(16)) u_xio (
    .status_word (extended_io_word),
    .enable_word (en_xio_q),
    .state_word  (st_xio_q),
    .hit         (hit_xio)
  );

  // The over-temperature flag reads low when hot, so a zero state word catches it.
  wire kill_req = hit_pri | hit_sec | hit_xio;
  wire ov_kill  = overvolt & driver_enable;
  wire keep_eff = keep_q & multi_q;
  // A disabled check (zero threshold) never trips.
  wire proc_low = (proc_trip_q != 16'h0000) && (processor_volts < proc_trip_q);

  // Write channel: address and data may arrive in either order.
  wire wr_go = aw_q & w_q & ~s_axi_bvalid;
  assign s_axi_awready = ~aw_q & ~s_axi_bvalid;
  assign s_axi_wready  = ~w_q & ~s_axi_bvalid;
  assign s_axi_arready = ~s_axi_rvalid;
  wire sw_wr = wr_go & (wstrb_q[1:0] == 2'b11);
  wire ld_args_len2 = (ld_opcode == `OPC_COND_CONFIG);
  wire ld_ext = (ld_opcode == `OPC_COND_CONFIG_EXT);
  wire cmd_drv_en = sw_wr && awaddr_q == `OFS_CONTROL && wdata_q[`CTL_DRV_EN_BIT];
  wire clr_wr = wr_go && awaddr_q == `OFS_CLEAR;

  function map_ok;
    input [7:0] a;
    begin
      map_ok = (a <= `OFS_CMD) && (a[1:0] == 2'b00);
    end
  endfunction

  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_q         <= 1'b0;
      w_q          <= 1'b0;
      awaddr_q     <= 8'h00;
      wdata_q      <= 32'h0000_0000;
      wstrb_q      <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_q     <= 1'b1;
        awaddr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_q     <= 1'b1;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end
      if (wr_go) begin
        aw_q         <= 1'b0;
        w_q          <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= map_ok(awaddr_q) ? `RESP_OKAY : `RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Configuration registers: serial commands and bus writes share them.
  always @(posedge aclk) begin
    if (!aresetn) begin
      en_pri_q    <= `ENABLE_PRI_RESET;
      st_pri_q    <= `STATE_PRI_RESET;
      en_sec_q    <= 16'h0000;
      st_sec_q    <= 16'h0000;
      en_xio_q    <= 16'h0000;
      st_xio_q    <= 16'h0000;
      recovery_q  <= `RECOVERY_RESET;
      proc_trip_q <= `PROC_TRIP_RESET;
      drv_trip_q  <= `DRV_TRIP_RESET;
      keep_q      <= 1'b0;
      multi_q     <= 1'b0;
    end else begin
      if (ld_done) begin
        if (ld_args_len2) begin
          en_pri_q <= ld_args[79:64];
          st_pri_q <= ld_args[95:80];
        end else if (ld_ext) begin
          en_pri_q <= ld_args[15:0];
          st_pri_q <= ld_args[31:16];
          en_sec_q <= ld_args[47:32];
          st_sec_q <= ld_args[63:48];
          en_xio_q <= ld_args[79:64];
          st_xio_q <= ld_args[95:80];
        end else if (ld_opcode == `OPC_RECOVERY) begin
          recovery_q <= ld_args[95:80];
        end else if (ld_opcode == `OPC_PROC_TRIP) begin
          proc_trip_q <= ld_args[95:80];
        end else if (ld_opcode == `OPC_DRV_TRIP) begin
          drv_trip_q <= ld_args[95:80];
        end
      end else if (sw_wr) begin
        case (awaddr_q)
          `OFS_ENABLE_PRI: en_pri_q <= wdata_q[15:0];
          `OFS_STATE_PRI:  st_pri_q <= wdata_q[15:0];
          `OFS_ENABLE_SEC: en_sec_q <= wdata_q[15:0];
          `OFS_STATE_SEC:  st_sec_q <= wdata_q[15:0];
          `OFS_ENABLE_XIO: en_xio_q <= wdata_q[15:0];
          `OFS_STATE_XIO:  st_xio_q <= wdata_q[15:0];
          `OFS_RECOVERY:   recovery_q <= wdata_q[15:0];
          `OFS_PROC_TRIP:  proc_trip_q <= wdata_q[15:0];
          `OFS_DRV_TRIP:   drv_trip_q <= wdata_q[15:0];
          `OFS_CONTROL: begin
            keep_q  <= wdata_q[`CTL_KEEP_BIT];
            multi_q <= wdata_q[`CTL_MULTI_BIT];
          end
          default: begin
          end
        endcase
      end
      // The trip wins over any write in the same cycle so it cannot refire.
      if (proc_low) begin
        proc_trip_q <= 16'h0000;
        drv_trip_q  <= 16'h0000;
      end
    end
  end

  // Shutdown sequencing and driver control.
  always @(posedge aclk) begin
    if (!aresetn) begin
      driver_enable      <= 1'b0;
      short_windings     <= 1'b0;
      abort_motion       <= 1'b0;
      recovery_start     <= 1'b0;
      recovery_addr      <= 16'h0000;
      killed_q           <= 1'b0;
      ov_seen_q          <= 1'b0;
      low_voltage_status <= 1'b0;
      power_low_start    <= 1'b0;
    end else begin
      abort_motion    <= 1'b0;
      recovery_start  <= 1'b0;
      power_low_start <= 1'b0;
      short_windings  <= overvolt & (driver_enable | short_windings);
      if (cmd_drv_en) begin
        driver_enable <= 1'b1;
      end
      if (ov_kill) begin
        driver_enable <= 1'b0;
        ov_seen_q     <= 1'b1;
      end
      if (kill_req && !killed_q) begin
        killed_q <= 1'b1;
        if (!keep_eff || recovery_q == `RECOVERY_NONE) begin
          driver_enable <= 1'b0;
        end
        if (recovery_q == `RECOVERY_NONE) begin
          abort_motion <= 1'b1;
        end else if (recovery_q == `RECOVERY_ADDR0) begin
          recovery_start <= 1'b1;
          recovery_addr  <= 16'h0000;
        end else begin
          recovery_start <= 1'b1;
          recovery_addr  <= recovery_q;
        end
      end else if (!kill_req && clr_wr && wdata_q[`ST_KILLED_BIT]) begin
        killed_q <= 1'b0;
      end
      if (proc_low) begin
        low_voltage_status <= 1'b1;
        power_low_start    <= 1'b1;
      end else if (clr_wr && wdata_q[`ST_LOWVOLT_BIT]) begin
        low_voltage_status <= 1'b0;
      end
      if (!ov_kill && clr_wr && wdata_q[`ST_OVERVOLT_BIT]) begin
        ov_seen_q <= 1'b0;
      end
    end
  end

  // Read channel.
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= `RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= map_ok(s_axi_araddr) ? `RESP_OKAY : `RESP_SLVERR;
      case (s_axi_araddr)
        `OFS_ENABLE_PRI: s_axi_rdata <= {16'h0000, en_pri_q};
        `OFS_STATE_PRI:  s_axi_rdata <= {16'h0000, st_pri_q};
        `OFS_ENABLE_SEC: s_axi_rdata <= {16'h0000, en_sec_q};
        `OFS_STATE_SEC:  s_axi_rdata <= {16'h0000, st_sec_q};
        `OFS_ENABLE_XIO: s_axi_rdata <= {16'h0000, en_xio_q};
        `OFS_STATE_XIO:  s_axi_rdata <= {16'h0000, st_xio_q};
        `OFS_RECOVERY:   s_axi_rdata <= {16'h0000, recovery_q};
        `OFS_PROC_TRIP:  s_axi_rdata <= {16'h0000, proc_trip_q};
        `OFS_DRV_TRIP:   s_axi_rdata <= {16'h0000, drv_trip_q};
        `OFS_CONTROL:    s_axi_rdata <= {29'h0, driver_enable, multi_q, keep_q};
        `OFS_STATUS:     s_axi_rdata <= {29'h0, low_voltage_status, ov_seen_q, killed_q};
        default:         s_axi_rdata <= 32'h0000_0000;
      endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end
endmodule

// *** core/word_loader.v ***
// Purpose: Collects the words of a serial configuration command.
// Assumes: One word per cycle on cmd_valid; the opcode word comes first.
// Notes: Emits a one-cycle done pulse with all words captured.
`timescale 1ns/1ps
`include "kill_monitor_defines.vh"
module word_loader (
  input  wire        aclk,
  input  wire        aresetn,
  input  wire        cmd_valid,
  input  wire [15:0] cmd_word,
  output reg         done,
  output reg  [15:0] opcode,
  output reg  [95:0] args
);
  reg [2:0] need_q;
  reg [2:0] cnt_q;
  reg [2:0] need;
  always @* begin
    case (cmd_word)
      `OPC_COND_CONFIG:     need = 3'd2;
      `OPC_COND_CONFIG_EXT: need = 3'd6;
      `OPC_RECOVERY:        need = 3'd1;
      `OPC_PROC_TRIP:       need = 3'd1;
      `OPC_DRV_TRIP:        need = 3'd1;
      default:              need = 3'd0;
    endcase
  end
  always @(posedge aclk) begin
    if (!aresetn) begin
      need_q <= 3'd0;
      cnt_q  <= 3'd0;
      done   <= 1'b0;
      opcode <= 16'h0000;
      args   <= 96'h0;
    end else begin
      done <= 1'b0;
      if (cmd_valid) begin
        if (cnt_q == 3'd0) begin
          opcode <= cmd_word;
          need_q <= need;
          if (need != 3'd0) begin
            cnt_q <= 3'd1;
          end
        end else begin
          args <= {cmd_word, args[95:16]};
          if (cnt_q == need_q) begin
            cnt_q <= 3'd0;
            done  <= 1'b1;
          end else begin
            cnt_q <= cnt_q + 3'd1;
          end
        end
      end
    end
  end
endmodule

// *** sim/host_cmd_model.sv ***
// Purpose: Host that issues serial configuration commands.
// Assumes: One word taken per aclk edge while cmd_valid is high.
// Notes: Between commands the word shows the inverse of the last one sent.
`timescale 1ns/1ps
module host_cmd_model (
  input  wire        aclk,
  output reg         cmd_valid,
  output reg  [15:0] cmd_word
);
  initial begin
    cmd_valid = 1'b0;
    cmd_word  = 16'h0000;
  end
  // Opcode first, then every argument word back to back.
  task send(input logic [15:0] w [$]);
    foreach (w[i]) begin
      @(posedge aclk);
      cmd_valid <= 1'b1;
      cmd_word  <= w[i];
    end
    @(posedge aclk);
    cmd_valid <= 1'b0;
    cmd_word  <= ~w[w.size()-1];
    // The registers take the words one edge after the last word, so let that edge pass.
    @(posedge aclk);
  endtask
endmodule

// *** sim/kill_mon_chk.sv ***
// Purpose: Port-level checks for the shutdown supervisor.
// Assumes: One aclk domain with a synchronous active-low reset.
// Notes: Bound to the top design module below the checker.
`timescale 1ns/1ps
module kill_mon_chk (
  input wire aclk,
  input wire aresetn,
  input wire s_axi_awready,
  input wire s_axi_bvalid,
  input wire s_axi_arvalid,
  input wire s_axi_arready,
  input wire s_axi_rvalid,
  input wire overvolt,
  input wire driver_enable,
  input wire short_windings,
  input wire abort_motion,
  input wire recovery_start,
  input wire low_voltage_status,
  input wire power_low_start
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  sequence ov_hit;
    overvolt && driver_enable;
  endsequence
  a_ov_cuts_drv: assert property (ov_hit |=> !driver_enable)
    else $error("driver left on under over-voltage");
  a_ov_shorts: assert property (ov_hit |=> short_windings)
    else $error("windings not shorted under over-voltage");
  a_short_ends: assert property (!overvolt |=> !short_windings)
    else $error("windings still shorted after over-voltage");
  a_abort_pulse: assert property (abort_motion |=> !abort_motion)
    else $error("abort longer than one cycle");
  a_recov_pulse: assert property (recovery_start |=> !recovery_start)
    else $error("recovery start longer than one cycle");
  a_abort_drv_off: assert property (abort_motion |-> ##[0:1] !driver_enable)
    else $error("driver on after abort");
  a_plr_status: assert property (power_low_start |-> low_voltage_status)
    else $error("power-low start without low-voltage status");
  a_b_refuse: assert property (s_axi_bvalid |-> !s_axi_awready)
    else $error("write address taken during response");
  a_rd_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data late");
endmodule
bind motor_kill_condition_monitor kill_mon_chk u_chk (
  .aclk, .aresetn, .s_axi_awready, .s_axi_bvalid, .s_axi_arvalid, .s_axi_arready,
  .s_axi_rvalid, .overvolt, .driver_enable, .short_windings, .abort_motion,
  .recovery_start, .low_voltage_status, .power_low_start
);

// *** sim/motor_kill_condition_monitor_test.sv ***
// Purpose: Self-checking bench for the shutdown supervisor.
// Assumes: 200 MHz aclk, synchronous active-low reset.
// Notes: Registers over AXI4-Lite, commands through the host model.
`timescale 1ns/1ps
`include "kill_monitor_defines.vh"
module motor_kill_condition_monitor_test;
  logic        aclk, aresetn, overvolt;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata;
  logic [3:0]  s_axi_wstrb;
  logic        s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  logic [15:0] primary_status_word, secondary_status_word, extended_io_word, processor_volts;
  wire         s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire  [1:0]  s_axi_bresp, s_axi_rresp;
  wire  [31:0] s_axi_rdata;
  wire         cmd_valid, driver_enable, short_windings, abort_motion;
  wire         recovery_start, low_voltage_status, power_low_start;
  wire  [15:0] cmd_word, recovery_addr;
  int          errors, check_count, n_abort, n_rec, n_plr;
  logic [31:0] last_addr;
  logic [15:0] masks [3] = '{16'h0010, 16'h0080, 16'h0100};
  logic [15:0] rv [2] = '{16'hFFFF, 16'h021E};
  logic [31:0] ctl [2] = '{32'h0000_0001, 32'h0000_0003};

  motor_kill_condition_monitor dut (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .cmd_valid, .cmd_word,
    .primary_status_word, .secondary_status_word, .extended_io_word, .overvolt,
    .processor_volts, .driver_enable, .short_windings, .abort_motion,
    .recovery_start, .recovery_addr, .low_voltage_status, .power_low_start
  );
  host_cmd_model h (.aclk, .cmd_valid, .cmd_word);

  initial begin
    aclk = 1'b0;
    forever #2.5 aclk = ~aclk;
  end
  always @(posedge aclk) begin
    if (abort_motion) n_abort++;
    if (power_low_start) n_plr++;
    if (recovery_start) begin
      n_rec++;
      last_addr = {16'h0000, recovery_addr};
    end
  end

  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task chk_bit(input string nm, input logic e, input logic g);
    chk(nm, {31'h0, e}, {31'h0, g});
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    int k;
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    for (k = 0; k < 50; k++) begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) break;
    end
    chk("bresp", {30'h0, er}, {30'h0, s_axi_bresp});
  endtask
  task rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
    int k;
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    for (k = 0; k < 50; k++) begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) break;
    end
    chk("rdata", e, s_axi_rdata);
    chk("rresp", {30'h0, er}, {30'h0, s_axi_rresp});
  endtask
  // Clears a latched shutdown, sets the control word and enables the driver.
  task arm(input logic [31:0] c);
    wr(`OFS_CLEAR, 32'h0000_0001, `RESP_OKAY);
    wr(`OFS_CONTROL, c | 32'h0000_0004, `RESP_OKAY);
    n_abort = 0;
    n_rec = 0;
  endtask
  task expect_kill(input logic [31:0] na, input logic [31:0] nr, input logic de);
    repeat (4) @(posedge aclk);
    chk("abort_count", na, n_abort);
    chk("recovery_count", nr, n_rec);
    chk_bit("driver_enable", de, driver_enable);
  endtask
  task end_of_test;
    $display("checks %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  initial begin
    #100000;
    errors++;
    end_of_test();
  end
  initial begin
    aresetn = 1'b0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    s_axi_awaddr = 8'h00;
    s_axi_araddr = 8'h00;
    s_axi_wdata = 32'h0000_0000;
    s_axi_wstrb = 4'hF;
    overvolt = 1'b0;
    primary_status_word = 16'h0090;
    secondary_status_word = 16'h0000;
    extended_io_word = 16'h8000;
    processor_volts = 16'h0005;
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd(`OFS_ENABLE_PRI, 32'h0000_0080, `RESP_OKAY);
    rd(`OFS_STATE_PRI, 32'h0000_0000, `RESP_OKAY);
    rd(`OFS_DRV_TRIP, 32'h0000_000A, `RESP_OKAY);
    rd(8'h40, 32'h0000_0000, `RESP_SLVERR);
    wr(8'h40, 32'h0000_0001, `RESP_SLVERR);
    arm(32'h0000_0000);
    primary_status_word <= 16'hFFFF;
    expect_kill(0, 0, 1'b1);
    primary_status_word <= 16'h0010;
    expect_kill(1, 0, 1'b0);
    rd(`OFS_STATUS, 32'h0000_0001, `RESP_OKAY);
    primary_status_word <= 16'h0090;
    h.send('{`OPC_COND_CONFIG, 16'h0190, 16'h0100});
    rd(`OFS_ENABLE_PRI, 32'h0000_0190, `RESP_OKAY);
    rd(`OFS_STATE_PRI, 32'h0000_0100, `RESP_OKAY);
    arm(32'h0000_0000);
    primary_status_word <= 16'hFEFF;
    expect_kill(0, 0, 1'b1);
    foreach (masks[i]) begin
      arm(32'h0000_0000);
      primary_status_word <= 16'h0090 ^ masks[i];
      expect_kill(1, 0, 1'b0);
      primary_status_word <= 16'h0090;
    end
    foreach (rv[i]) begin
      h.send('{`OPC_RECOVERY, rv[i]});
      arm(32'h0000_0000);
      primary_status_word <= 16'h0190;
      expect_kill(0, 1, 1'b0);
      chk("recovery_addr", {16'h0000, rv[i] & {16{i[0]}}}, last_addr);
      rd(`OFS_STATUS, 32'h0000_0001, `RESP_OKAY);
      primary_status_word <= 16'h0090;
    end
    rd(`OFS_RECOVERY, 32'h0000_021E, `RESP_OKAY);
    foreach (ctl[i]) begin
      arm(ctl[i]);
      primary_status_word <= 16'h0190;
      expect_kill(0, 1, ctl[i][1]);
      primary_status_word <= 16'h0090;
    end
    arm(32'h0000_0003);
    overvolt <= 1'b1;
    repeat (2) @(posedge aclk);
    chk_bit("driver_enable", 1'b0, driver_enable);
    chk_bit("short_windings", 1'b1, short_windings);
    overvolt <= 1'b0;
    repeat (4) @(posedge aclk);
    chk_bit("short_windings", 1'b0, short_windings);
    h.send('{`OPC_COND_CONFIG_EXT, 16'h0000, 16'h0000, 16'h0001, 16'h0001,
             16'h8000, 16'h0000});
    rd(`OFS_ENABLE_SEC, 32'h0000_0001, `RESP_OKAY);
    rd(`OFS_ENABLE_XIO, 32'h0000_8000, `RESP_OKAY);
    arm(32'h0000_0000);
    secondary_status_word <= 16'h0001;
    expect_kill(0, 1, 1'b0);
    secondary_status_word <= 16'h0000;
    arm(32'h0000_0000);
    extended_io_word <= 16'h0000;
    expect_kill(0, 1, 1'b0);
    extended_io_word <= 16'h8000;
    chk_bit("low_voltage", 1'b0, low_voltage_status);
    processor_volts <= 16'h0018;
    h.send('{`OPC_PROC_TRIP, 16'h000C});
    rd(`OFS_PROC_TRIP, 32'h0000_000C, `RESP_OKAY);
    processor_volts <= 16'h0005;
    repeat (4) @(posedge aclk);
    chk_bit("low_voltage", 1'b1, low_voltage_status);
    chk("plr_count", 32'h0000_0001, n_plr);
    rd(`OFS_PROC_TRIP, 32'h0000_0000, `RESP_OKAY);
    rd(`OFS_DRV_TRIP, 32'h0000_0000, `RESP_OKAY);
    end_of_test();
  end
endmodule
